// *** verilog/phy_strap_latch.sv ***
// Strap capture, derived configuration registers and AXI4-Lite slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module phy_strap_latch
(
    input  wire logic        sys_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [7:0]  strap_pin_i,
    output logic      [7:0]  strap_pin_o,
    output logic      [7:0]  strap_pin_oe_o,
    input  wire logic [7:0]  func_out_i,
    output logic             mii_isolate_o,
    output logic             autoneg_enable_o,
    output logic             speed_100_o,
    output logic             full_duplex_o,
    output logic      [3:0]  advertise_o,
    output logic      [4:0]  station_address_o,
    output logic             config_done_o,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////
    strap_if sif ();
    assign sif.pin_level = strap_pin_i;

    strap_sampler u_sampler
    (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .bus       (sif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Capture runs a few cycles after release: an async reset may only load constants
    logic [2:0] cnt_q, cnt_d;
    logic       done_q, done_d;
    logic [7:0] raw_q, raw_d;
    logic [4:0] addr_q, addr_d;
    logic       iso_q, iso_d;
    logic       an_q, an_d;
    logic       spd_q, spd_d;
    logic       dup_q, dup_d;
    logic [3:0] adv_q, adv_d;
    logic [7:0] pin_o_q, pin_o_d;
    logic [7:0] pin_oe_q, pin_oe_d;
    logic       capture;
    logic       commit;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [7:0]  strap;

    logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [11:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        awready_q, awready_d, wready_q, wready_d;
    logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    assign strap   = sif.sync_level;
    assign capture = !done_q && (cnt_q == strap_pkg::CAPTURE_CYCLES);
    assign commit  = aw_hold_q && w_hold_q && !bvalid_q;
    assign wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    always_comb
    begin
        rd_hit  = 1'b1;
        rd_word = 32'h00000000;
        case (s_axi_araddr)
            strap_pkg::OFS_BMCR:
            begin
                rd_word[strap_pkg::BMCR_SPEED_BIT]  = spd_q;
                rd_word[strap_pkg::BMCR_AN_BIT]     = an_q;
                rd_word[strap_pkg::BMCR_ISO_BIT]    = iso_q;
                rd_word[strap_pkg::BMCR_DUPLEX_BIT] = dup_q;
            end
            strap_pkg::OFS_ANAR:
            begin
                rd_word[4:0] = strap_pkg::ANAR_SELECTOR;
                rd_word[strap_pkg::ANAR_CAP_LSB +: 4] = adv_q;
            end
            strap_pkg::OFS_PHY_CONTROL: rd_word[4:0] = addr_q;
            strap_pkg::OFS_STATUS:
            begin
                rd_word[7:0] = raw_q;
                rd_word[strap_pkg::STATUS_DONE_BIT] = done_q;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        cnt_d    = capture || done_q ? cnt_q : cnt_q + 3'h1;
        done_d   = done_q | capture;
        raw_d    = raw_q;
        addr_d   = addr_q;
        iso_d    = iso_q;
        an_d     = an_q;
        spd_d    = spd_q;
        dup_d    = dup_q;
        adv_d    = adv_q;
        pin_oe_d = {8{done_q}};
        pin_o_d  = func_out_i;
        if (capture)
        begin
            raw_d  = strap;
            addr_d = strap[strap_pkg::ADDR_MSB:strap_pkg::ADDR_LSB];
            iso_d  = (strap[strap_pkg::ADDR_MSB:strap_pkg::ADDR_LSB] == 5'h00);
            an_d   = strap[strap_pkg::AUTONEG_BIT];
            // Forced: high bit picks 100, low bit full duplex; zero is 10 half
            spd_d  = strap[strap_pkg::MODE_HIGH_BIT];
            dup_d  = strap[strap_pkg::MODE_LOW_BIT];
            // Order of adv bits: 100 full, 100 half, 10 full, 10 half
            if (!strap[strap_pkg::AUTONEG_BIT])
                adv_d = 4'hF;
            else
            begin
                case ({strap[strap_pkg::MODE_HIGH_BIT], strap[strap_pkg::MODE_LOW_BIT]})
                    2'h0:    adv_d = 4'h3;
                    2'h1:    adv_d = 4'hC;
                    2'h2:    adv_d = 4'h5;
                    default: adv_d = 4'hF;
                endcase
            end
        end
        else if (commit)
        begin
            // Isolate is never touched here, so writing address zero cannot isolate
            case (awaddr_q)
                strap_pkg::OFS_BMCR:
                begin
                    if (wstrb_q[1])
                    begin
                        spd_d = wdata_q[strap_pkg::BMCR_SPEED_BIT];
                        an_d  = wdata_q[strap_pkg::BMCR_AN_BIT];
                        dup_d = wdata_q[strap_pkg::BMCR_DUPLEX_BIT];
                    end
                end
                strap_pkg::OFS_ANAR:
                    adv_d = (adv_q & ~wmask[8:5]) | (wdata_q[8:5] & wmask[8:5]);
                strap_pkg::OFS_PHY_CONTROL:
                    addr_d = (addr_q & ~wmask[4:0]) | (wdata_q[4:0] & wmask[4:0]);
                default: addr_d = addr_q;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_q    <= 3'h0;
            done_q   <= 1'b0;
            raw_q    <= strap_pkg::STRAP_DEFAULT;
            addr_q   <= strap_pkg::STRAP_DEFAULT[4:0];
            iso_q    <= 1'b0;
            an_q     <= 1'b1;
            spd_q    <= 1'b1;
            dup_q    <= 1'b1;
            adv_q    <= 4'hF;
            pin_o_q  <= 8'h00;
            pin_oe_q <= 8'h00;
        end
        else
        begin
            cnt_q    <= cnt_d;
            done_q   <= done_d;
            raw_q    <= raw_d;
            addr_q   <= addr_d;
            iso_q    <= iso_d;
            an_q     <= an_d;
            spd_q    <= spd_d;
            dup_q    <= dup_d;
            adv_q    <= adv_d;
            pin_o_q  <= pin_o_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        aw_hold_d = (aw_hold_q & ~commit) | (s_axi_awvalid & awready_q);
        w_hold_d  = (w_hold_q & ~commit) | (s_axi_wvalid & wready_q);
        awaddr_d  = (s_axi_awvalid & awready_q) ? s_axi_awaddr : awaddr_q;
        wdata_d   = (s_axi_wvalid & wready_q) ? s_axi_wdata : wdata_q;
        wstrb_d   = (s_axi_wvalid & wready_q) ? s_axi_wstrb : wstrb_q;
        awready_d = !aw_hold_d;
        wready_d  = !w_hold_d;
        bvalid_d  = commit | (bvalid_q & ~s_axi_bready);
        bresp_d   = bresp_q;
        if (commit)
            bresp_d = (awaddr_q == strap_pkg::OFS_BMCR || awaddr_q == strap_pkg::OFS_ANAR ||
                       awaddr_q == strap_pkg::OFS_PHY_CONTROL || awaddr_q == strap_pkg::OFS_STATUS)
                      ? strap_pkg::RESP_OKAY : strap_pkg::RESP_SLVERR;
        rvalid_d  = (s_axi_arvalid & arready_q) | (rvalid_q & ~s_axi_rready);
        arready_d = !rvalid_d;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        if (s_axi_arvalid & arready_q)
        begin
            rdata_d = rd_word;
            rresp_d = rd_hit ? strap_pkg::RESP_OKAY : strap_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 12'h000;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= 2'h0;
        end
        else
        begin
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign strap_pin_o       = pin_o_q;
    assign strap_pin_oe_o    = pin_oe_q;
    assign mii_isolate_o     = iso_q;
    assign autoneg_enable_o  = an_q;
    assign speed_100_o       = spd_q;
    assign full_duplex_o     = dup_q;
    assign advertise_o       = adv_q;
    assign station_address_o = addr_q;
    assign config_done_o     = done_q;
    assign s_axi_awready     = awready_q;
    assign s_axi_wready      = wready_q;
    assign s_axi_bvalid      = bvalid_q;
    assign s_axi_bresp       = bresp_q;
    assign s_axi_arready     = arready_q;
    assign s_axi_rvalid      = rvalid_q;
    assign s_axi_rdata       = rdata_q;
    assign s_axi_rresp       = rresp_q;

    ////////////////////////////////////////////////////////////////////////
    property p_capture_raw;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        capture |=> (raw_q == $past(strap)) && done_q;
    endproperty
    a_capture_raw: assert property (p_capture_raw) else $error("strap capture wrong");

    property p_pins_released;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        !done_q |=> (strap_pin_oe_o == 8'h00);
    endproperty
    a_pins_released: assert property (p_pins_released) else $error("pin driven early");

    property p_pins_drive;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        done_q |=> (strap_pin_oe_o == 8'hFF) && (strap_pin_o == $past(func_out_i));
    endproperty
    a_pins_drive: assert property (p_pins_drive) else $error("pin not functional");

    property p_addr_load;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        capture |=> station_address_o == $past(strap[4:0]);
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address not loaded");

    property p_iso_strap;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        capture |=> mii_isolate_o == ($past(strap[4:0]) == 5'h00);
    endproperty
    a_iso_strap: assert property (p_iso_strap) else $error("isolate mismatch");

    property p_iso_stable;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        done_q && !capture |=> $stable(mii_isolate_o);
    endproperty
    a_iso_stable: assert property (p_iso_stable) else $error("isolate changed");

    property p_done_time;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        $rose(arst_n_i) |-> ##[4:6] config_done_o;
    endproperty
    a_done_time: assert property (p_done_time) else $error("capture late");

    property p_forced_mode;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        capture && !strap[7] |=> !autoneg_enable_o &&
            speed_100_o == $past(strap[6]) && full_duplex_o == $past(strap[5]);
    endproperty
    a_forced_mode: assert property (p_forced_mode) else $error("forced mode wrong");

    property p_adv_mode;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        capture && strap[7] && strap[6:5] == 2'h0 |=> autoneg_enable_o && advertise_o == 4'h3;
    endproperty
    a_adv_mode: assert property (p_adv_mode) else $error("advertise wrong");

    property p_read_answer;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");

    c_isolate: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i) $rose(mii_isolate_o));
    c_forced:  cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
                               capture && !strap[7]);
    c_write:   cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
                               s_axi_bvalid && s_axi_bready);
endmodule

`default_nettype wire

// *** verilog/strap_pkg.sv ***
// Constants and register map for the strap capture block
//
// Overview of operation
// - Strap pin levels are sampled at reset and select the initial configuration.
// - After reset release each strap pin returns to driving its functional output.
// - Five address straps load the control register address field, bits four to zero.
// - Every strapped address value zero through thirty-one is accepted as valid.
// - A strapped address of all zeros puts the MAC interface into isolate.
// - Software writing address zero never enters isolate; only strapped zero does.
// - Unstrapped address defaults to one: bit zero pulled up, upper bits down.
// - Mode straps pick forced mode or advertised abilities per autoneg strap.
// - Autoneg and mode straps load basic control and advertisement registers.
package strap_pkg;
    localparam int          STRAP_W         = 8;
    localparam logic [7:0]  STRAP_DEFAULT   = 8'hE1;
    localparam int          ADDR_LSB        = 0;
    localparam int          ADDR_MSB        = 4;
    localparam int          MODE_LOW_BIT    = 5;
    localparam int          MODE_HIGH_BIT   = 6;
    localparam int          AUTONEG_BIT     = 7;
    localparam logic [2:0]  CAPTURE_CYCLES  = 3'h4;
    localparam logic [11:0] OFS_BMCR        = 12'h000;
    localparam logic [11:0] OFS_ANAR        = 12'h004;
    localparam logic [11:0] OFS_PHY_CONTROL = 12'h008;
    localparam logic [11:0] OFS_STATUS      = 12'h00C;
    localparam int          BMCR_SPEED_BIT  = 13;
    localparam int          BMCR_AN_BIT     = 12;
    localparam int          BMCR_ISO_BIT    = 10;
    localparam int          BMCR_DUPLEX_BIT = 8;
    localparam int          ANAR_CAP_LSB    = 5;
    localparam logic [4:0]  ANAR_SELECTOR   = 5'h01;
    localparam int          STATUS_DONE_BIT = 8;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// *** verilog/strap_sampler.sv ***
// Strap pin synchroniser and the interface that carries its result
`timescale 1ns/1ns
`default_nettype none

interface strap_if;
    logic [7:0] pin_level;
    logic [7:0] sync_level;
    modport sampler (input pin_level, output sync_level);
    modport user    (output pin_level, input sync_level);
endinterface

module strap_sampler
(
    input  wire logic     sys_clk_i,
    input  wire logic     arst_n_i,
    strap_if.sampler      bus
);
    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < strap_pkg::STRAP_W; g++)
        begin : g_bit
            logic meta_q;
            logic meta_d;
            logic sync_q;
            logic sync_d;
            always_comb
            begin
                meta_d = bus.pin_level[g];
                sync_d = meta_q;
            end
            // Reset value mirrors the internal pull so an idle pin reads its default
            always_ff @(posedge sys_clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    meta_q <= strap_pkg::STRAP_DEFAULT[g];
                    sync_q <= strap_pkg::STRAP_DEFAULT[g];
                end
                else
                begin
                    meta_q <= meta_d;
                    sync_q <= sync_d;
                end
            end
            assign bus.sync_level[g] = sync_q;
        end
    endgenerate
endmodule

`default_nettype wire

// *** dv/strap_board.sv ***
// Board model: strap resistors and weak internal pulls on the strap pins
`timescale 1ns/1ns
`default_nettype none

module strap_board
(
    input  wire logic [7:0] strap_val_i,
    input  wire logic [7:0] fitted_i,
    input  wire logic [7:0] dev_out_i,
    input  wire logic [7:0] dev_oe_i,
    output logic      [7:0] level_o
);
    // Weak pulls: address bit 0, autoneg and the two mode pins up, address 4:1 down
    localparam logic [7:0] WEAK_PULL = 8'hE1;

    // A fitted resistor beats the weak pull; a driving device beats both
    always_comb
    begin
        for (int b = 0; b < 8; b++)
        begin
            if (dev_oe_i[b])
                level_o[b] = dev_out_i[b];
            else if (fitted_i[b])
                level_o[b] = strap_val_i[b];
            else
                level_o[b] = WEAK_PULL[b];
        end
    end
endmodule

`default_nettype wire

// *** dv/phy_strap_latch_tb_top.sv ***
// Self-checking bench for the strap capture block
`timescale 1ns/1ns
`default_nettype none

`define check_eq(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module phy_strap_latch_tb_top;
    logic        sys_clk;
    logic        arst_n;
    logic [7:0]  strap_val;
    logic [7:0]  fitted;
    logic [7:0]  func_out;
    wire  [7:0]  pin_level;
    wire  [7:0]  strap_pin_o;
    wire  [7:0]  strap_pin_oe_o;
    wire         mii_isolate_o;
    wire         autoneg_enable_o;
    wire         speed_100_o;
    wire         full_duplex_o;
    wire  [3:0]  advertise_o;
    wire  [4:0]  station_address_o;
    wire         config_done_o;
    logic [11:0] s_axi_awaddr;
    logic        s_axi_awvalid;
    wire         s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    wire         s_axi_wready;
    wire  [1:0]  s_axi_bresp;
    wire         s_axi_bvalid;
    logic        s_axi_bready;
    logic [11:0] s_axi_araddr;
    logic        s_axi_arvalid;
    wire         s_axi_arready;
    wire  [31:0] s_axi_rdata;
    wire  [1:0]  s_axi_rresp;
    wire         s_axi_rvalid;
    logic        s_axi_rready;
    int          bad_count;
    int          n_checks;
    logic [4:0]  addr_tab [8];

    phy_strap_latch u_phy_strap_latch (.sys_clk_i(sys_clk), .arst_n_i(arst_n),
        .strap_pin_i(pin_level), .strap_pin_o(strap_pin_o), .strap_pin_oe_o(strap_pin_oe_o),
        .func_out_i(func_out), .mii_isolate_o(mii_isolate_o),
        .autoneg_enable_o(autoneg_enable_o), .speed_100_o(speed_100_o),
        .full_duplex_o(full_duplex_o), .advertise_o(advertise_o),
        .station_address_o(station_address_o), .config_done_o(config_done_o),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    strap_board u_strap_board (.strap_val_i(strap_val), .fitted_i(fitted),
        .dev_out_i(strap_pin_o), .dev_oe_i(strap_pin_oe_o), .level_o(pin_level));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic give_up;
        bad_count++;
        $display("unexpected at %0t: wait ran out", $time);
        conclude();
    endtask

    // Nonblocking drives after the rising edge keep a ready from being lowered and raised in one step
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while ((s_axi_awvalid || s_axi_wvalid) && n < 50);
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (s_axi_bvalid !== 1'b1 && n < 100);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 100)
            give_up();
        @(posedge sys_clk);
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (s_axi_arready !== 1'b1 && n < 50);
        s_axi_arvalid <= 1'b0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (s_axi_rvalid !== 1'b1 && n < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 100)
            give_up();
        @(posedge sys_clk);
    endtask

    task automatic apply_reset(input logic [7:0] val, input logic [7:0] fit);
        int n;
        strap_val <= val;
        fitted <= fit;
        arst_n <= 1'b0;
        repeat (20) @(posedge sys_clk);
        `check_eq({config_done_o, strap_pin_oe_o}, 9'h000)
        arst_n <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (config_done_o !== 1'b1 && n < 40);
        if (n >= 40)
            give_up();
        repeat (2) @(posedge sys_clk);
    endtask

    // Advertised abilities {100F,100H,10F,10H} per {high,low} mode strap
    function automatic logic [3:0] exp_adv(input logic [1:0] m);
        case (m)
            2'h0: exp_adv = 4'h3;
            2'h1: exp_adv = 4'hC;
            2'h2: exp_adv = 4'h5;
            default: exp_adv = 4'hF;
        endcase
    endfunction

    task automatic check_config(input logic [7:0] s);
        logic [31:0] d;
        logic [1:0]  r;
        logic [3:0]  adv;
        adv = s[7] ? exp_adv(s[6:5]) : 4'hF;
        `check_eq(station_address_o, s[4:0])
        `check_eq(mii_isolate_o, (s[4:0] == 5'h00))
        `check_eq(autoneg_enable_o, s[7])
        `check_eq(advertise_o, adv)
        if (!s[7])
        begin
            `check_eq({speed_100_o, full_duplex_o}, s[6:5])
        end
        axi_read(12'h008, d, r);
        `check_eq({r, d[4:0]}, {strap_pkg::RESP_OKAY, s[4:0]})
        axi_read(12'h000, d, r);
        `check_eq({d[12], d[10]}, {s[7], s[4:0] == 5'h00})
        axi_read(12'h004, d, r);
        `check_eq(d[8:0], {adv, 5'h01})
        axi_read(12'h00C, d, r);
        `check_eq(d[8:0], {1'b1, s})
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic sc_defaults;
        apply_reset(8'h1E, 8'h00);
        check_config(8'hE1);
    endtask

    // Every autoneg/mode code, with address extremes including zero
    task automatic sc_strap_table;
        for (int i = 0; i < 8; i++)
        begin
            apply_reset({i[2:0], addr_tab[i]}, 8'hFF);
            check_config({i[2:0], addr_tab[i]});
        end
    endtask

    task automatic sc_soft_zero;
        logic [1:0] r;
        apply_reset(8'hF5, 8'hFF);
        axi_write(12'h008, 32'h0000_0000, 4'hF, r);
        `check_eq(station_address_o, 5'h00)
        axi_write(12'h000, 32'h0000_1400, 4'hF, r);
        `check_eq({r, mii_isolate_o}, {strap_pkg::RESP_OKAY, 1'b0})
        `check_eq({autoneg_enable_o, speed_100_o, full_duplex_o}, 3'h4)
        // Byte 1 strobe low: BMCR bits ignored, ANAR bit 8 kept
        axi_write(12'h000, 32'h0000_2100, 4'h1, r);
        axi_write(12'h004, 32'h0000_0000, 4'h1, r);
        `check_eq(r, strap_pkg::RESP_OKAY)
        `check_eq({autoneg_enable_o, speed_100_o, full_duplex_o}, 3'h4)
        `check_eq(advertise_o, 4'h8)
    endtask

    task automatic sc_unmapped_and_release;
        logic [31:0] d;
        logic [1:0]  r;
        apply_reset(8'hE3, 8'hFF);
        `check_eq(strap_pin_oe_o, 8'hFF)
        axi_read(12'h010, d, r);
        `check_eq({r, d}, {strap_pkg::RESP_SLVERR, 32'h0})
        axi_write(12'h010, 32'h0000_0000, 4'hF, r);
        `check_eq(r, strap_pkg::RESP_SLVERR)
        axi_write(12'h00C, 32'h0000_0000, 4'hF, r);
        axi_read(12'h00C, d, r);
        `check_eq({r, d[8:0]}, {strap_pkg::RESP_OKAY, 9'h1E3})
        // Pins now carry core outputs; later board levels must not re-capture
        func_out <= 8'h5A;
        strap_val <= 8'h00;
        repeat (4) @(posedge sys_clk);
        `check_eq({strap_pin_o, pin_level}, 16'h5A5A)
        `check_eq({mii_isolate_o, station_address_o}, 6'h03)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (60000) @(posedge sys_clk);
        give_up();
    end

    initial
    begin
        arst_n = 1'b0;
        strap_val = 8'h00;
        fitted = 8'h00;
        func_out = 8'h00;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        bad_count = 0;
        n_checks = 0;
        addr_tab = '{5'h00, 5'h1F, 5'h15, 5'h0A, 5'h01, 5'h10, 5'h02, 5'h04};
        @(posedge sys_clk);
        sc_defaults();
        sc_strap_table();
        sc_soft_zero();
        sc_unmapped_and_release();
        conclude();
    end
endmodule

`default_nettype wire
